// >>> src/tthd_params.svh
`ifndef TTHD_PARAMS_SVH
`define TTHD_PARAMS_SVH

// register pages
`define TTHD_PAGE_ACQ            8'h22
`define TTHD_PAGE_SLICER         8'h23

// acquisition page offsets
`define TTHD_OFS_PTR_HIGH        8'hf2
`define TTHD_OFS_PTR_LOW         8'hf3
`define TTHD_OFS_SCHEME          8'hfb
`define TTHD_OFS_HAM_HIGH        8'hfd
`define TTHD_OFS_HAM_MID         8'hfe
`define TTHD_OFS_HAM_LOW         8'hff

// slicer page offsets
`define TTHD_OFS_SLICER_CTRL     8'hf8
`define TTHD_OFS_DAC_INIT        8'hf9
`define TTHD_OFS_AMPLIFIER_BYPASS_SEL      8'hff

// reset values
`define TTHD_RST_PTR             13'h0000
`define TTHD_RST_SLICER_CTRL     8'h06
`define TTHD_RST_DAC_INIT        6'h0b
`define TTHD_RST_AMPLIFIER_BYPASS_SEL      8'h00

// field positions
`define TTHD_BIT_SCHEME          7
`define TTHD_BIT_SLICER_ON       7
`define TTHD_BIT_EXT_SEARCH      6
`define TTHD_BIT_GAIN_HI         5
`define TTHD_BIT_GAIN_LO         4
`define TTHD_BIT_BYPASS          2
`define TTHD_BIT_ADC_SEL         0
`define TTHD_BIT_FLAG_HIGH       7

// run-in search start lines
`define TTHD_LINE_F1_NORMAL      9'h006
`define TTHD_LINE_F2_NORMAL      9'h13e
`define TTHD_LINE_F1_EXT         9'h002
`define TTHD_LINE_F2_EXT         9'h13b

// pre-amplifier gain, in tenths
`define TTHD_GAIN_00             6'h0c
`define TTHD_GAIN_01             6'h14
`define TTHD_GAIN_10             6'h1e
`define TTHD_GAIN_11             6'h26

`endif

// >>> src/tthd_pkg.sv
package tthd_pkg;

    typedef enum logic {
        TTHD_MODE_84   = 1'b0,
        TTHD_MODE_2418 = 1'b1
    } tthd_mode_e;

    typedef logic [7:0]  tthd_byte_t;
    typedef logic [23:0] tthd_word_t;
    typedef logic [17:0] tthd_data_t;

endpackage

// >>> src/tthd_dec_if.sv
`timescale 1ns/10ps
interface tthd_dec_if;
    import tthd_pkg::*;

    tthd_word_t word;
    tthd_mode_e mode;
    logic       err;
    tthd_data_t data;

    modport dec (
        input  word,
        input  mode,
        output err,
        output data
    );

    modport user (
        output word,
        output mode,
        input  err,
        input  data
    );
endinterface

// >>> src/tthd_hamming.sv
`timescale 1ns/10ps
module tthd_hamming
    import tthd_pkg::*;
(
    tthd_dec_if.dec dec
);
    // parity tests over positions 1 to 23; bit 23 is overall parity only
    function automatic logic [4:0] h24_tests(input tthd_word_t w);
        logic [4:0] t;
        logic [4:0] pos;
        t = 5'h00;
        for (int i = 0; i < 23; i++) begin
            pos = 5'(i + 1);
            for (int k = 0; k < 5; k++) begin
                if (pos[k]) begin
                    t[k] = t[k] ^ w[i];
                end
            end
        end
        return t;
    endfunction

    logic [4:0]  syn;
    logic        par_ok;
    tthd_word_t  flip_mask;
    tthd_word_t  fixed;
    logic        err24;
    tthd_data_t  d24;
    tthd_byte_t  b;
    logic [2:0]  abc;
    logic        d_ok;
    logic        err84;
    logic [3:0]  d84;

    assign syn       = ~h24_tests(dec.word);
    assign par_ok    = ^dec.word;
    assign flip_mask = (!par_ok && syn != 5'h00 && syn <= 5'h17) ?
                       (24'h000001 << (syn - 5'h01)) : 24'h000000;
    assign fixed     = dec.word ^ flip_mask;
    assign err24     = (par_ok && syn != 5'h00) || (!par_ok && syn > 5'h17);
    assign d24       = {fixed[22:16], fixed[14:8], fixed[6:4], fixed[2]};

    assign b     = dec.word[7:0];
    assign abc   = {b[0] ^ b[1] ^ b[5] ^ b[7], b[1] ^ b[2] ^ b[3] ^ b[7],
                    b[1] ^ b[3] ^ b[4] ^ b[5]};
    assign d_ok  = ^b;
    assign err84 = d_ok && abc != 3'h7;
    assign d84   = {b[7] ^ (!d_ok && abc == 3'h1), b[5] ^ (!d_ok && abc == 3'h2),
                    b[3] ^ (!d_ok && abc == 3'h4), b[1] ^ (!d_ok && abc == 3'h0)};

    assign dec.err  = (dec.mode == TTHD_MODE_2418) ? err24 : err84;
    assign dec.data = (dec.mode == TTHD_MODE_2418) ? d24 : {14'h0000, d84};
endmodule // tthd_hamming

// >>> src/tthd_regs.sv
`timescale 1ns/10ps
`include "tthd_params.svh"

// How it works
// - three byte registers form one word; decoded result reads back in place
// - 24/18 input bits follow the fixed parity and data order
// - 24/18 readback packs flag and data fields, with zero bits between the data groups
// - 24/18 uncorrectable word sets a sticky flag cleared only by software
// - while the flag is set every decoded data bit reads zero
// - in 8/4 mode the upper sixteen written bits are not decoded; a zero written to bit 23 still clears the flag
// - 8/4 readback holds flag in bit 4, data in bits 3:0
// - 8/4 uncorrectable byte sets the flag; software clears it
// - thirteen bit write pointer split over two byte registers
// - pointer increments on each store unless software loads it that cycle; software loads outside blanking
// - slicer on bit powers slicer down when zero, slices when one
// - extended search moves run-in start lines from 6/318 to 2/315
// - two bit gain code selects 1.2, 2.0, 3.0 or 3.8
// - slicer dac reloads from six bit init field each line start
// - bypass bit zero feeds amplified video, one bypasses amplifier
// - converter select routes sync amplitude or on-chip reference
// - scheme bit zero selects 8/4, one selects 24/18
module tthd_regs
    import tthd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] reg_page,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       store_strobe,
    input  wire logic       vbi_active,
    input  wire logic       line_start,
    output logic     [12:0] acq_write_address,
    output logic            slicer_on,
    output logic            slicer_power_down,
    output logic      [8:0] runin_line_field1,
    output logic      [8:0] runin_line_field2,
    output logic      [1:0] amplifier_bypass_gain_field,
    output logic      [5:0] amplifier_bypass_gain_x10,
    output logic      [5:0] slicer_dac_value,
    output logic            slicer_dac_reload,
    output logic            amplifier_bypass,
    output logic            slicer_feed_amplified,
    output logic            converter_source_select,
    output logic            route_sync_amplitude_signal,
    output logic            route_onchip_reference_signal
);

    // register hit decode
    function automatic logic reg_hit(
        input logic [7:0] page,
        input logic [7:0] addr,
        input logic [7:0] want_page,
        input logic [7:0] want_addr
    );
        return (page == want_page) && (addr == want_addr);
    endfunction

    // gain code lookup
    function automatic logic [5:0] gain_lookup(input logic [1:0] code);
        logic [5:0] g;
        g = `TTHD_GAIN_00;
        unique case (code)
            2'h0: g = `TTHD_GAIN_00;
            2'h1: g = `TTHD_GAIN_01;
            2'h2: g = `TTHD_GAIN_10;
            2'h3: g = `TTHD_GAIN_11;
        endcase
        return g;
    endfunction

    // reset images of the byte registers, indexed by field
    localparam tthd_byte_t slicer_ctrl_reset = `TTHD_RST_SLICER_CTRL;
    localparam tthd_byte_t amplifier_bypass_sel_reset  = `TTHD_RST_AMPLIFIER_BYPASS_SEL;

    tthd_dec_if dec_bus ();

    tthd_byte_t  hamming_word_high;
    tthd_byte_t  hamming_word_mid;
    tthd_mode_e  decode_scheme_select;
    tthd_mode_e  result_mode;
    tthd_data_t  result_data;
    logic        result_flag;
    logic [12:0] write_pointer;
    logic        slicer_on_bit;
    logic        extended_runin_search;
    logic [1:0]  gain_code;
    logic [5:0]  dac_start_value;
    logic        bypass_bit;
    logic        adc_sel_bit;
    logic [5:0]  dac_value;
    logic        dac_reload;
    logic [8:0]  runin_field1;
    logic [8:0]  runin_field2;
    logic [5:0]  gain_x10;
    tthd_byte_t  rdata;

    logic        hit_ptr_high;
    logic        hit_ptr_low;
    logic        hit_scheme;
    logic        hit_ham_high;
    logic        hit_ham_mid;
    logic        hit_ham_low;
    logic        hit_slicer_ctrl;
    logic        hit_dac_init;
    logic        hit_amplifier_bypass_sel;
    logic        wr_ptr_high;
    logic        wr_ptr_low;
    logic        ptr_load_ok;
    logic        decode_trigger;
    logic        flag_clear;
    logic        next_flag;
    tthd_data_t  next_data;
    tthd_word_t  read_word;
    logic [12:0] next_pointer;
    tthd_byte_t  slicer_ctrl_read;
    tthd_byte_t  dac_init_read;
    tthd_byte_t  amplifier_bypass_sel_read;
    tthd_byte_t  next_rdata;

    // address decode
    assign hit_ptr_high    = reg_hit(reg_page, reg_addr, `TTHD_PAGE_ACQ, `TTHD_OFS_PTR_HIGH);
    assign hit_ptr_low     = reg_hit(reg_page, reg_addr, `TTHD_PAGE_ACQ, `TTHD_OFS_PTR_LOW);
    assign hit_scheme      = reg_hit(reg_page, reg_addr, `TTHD_PAGE_ACQ, `TTHD_OFS_SCHEME);
    assign hit_ham_high    = reg_hit(reg_page, reg_addr, `TTHD_PAGE_ACQ, `TTHD_OFS_HAM_HIGH);
    assign hit_ham_mid     = reg_hit(reg_page, reg_addr, `TTHD_PAGE_ACQ, `TTHD_OFS_HAM_MID);
    assign hit_ham_low     = reg_hit(reg_page, reg_addr, `TTHD_PAGE_ACQ, `TTHD_OFS_HAM_LOW);
    assign hit_slicer_ctrl = reg_hit(reg_page, reg_addr, `TTHD_PAGE_SLICER,
                                     `TTHD_OFS_SLICER_CTRL);
    assign hit_dac_init    = reg_hit(reg_page, reg_addr, `TTHD_PAGE_SLICER,
                                     `TTHD_OFS_DAC_INIT);
    assign hit_amplifier_bypass_sel  = reg_hit(reg_page, reg_addr, `TTHD_PAGE_SLICER,
                                     `TTHD_OFS_AMPLIFIER_BYPASS_SEL);

    assign decode_trigger = reg_wr && hit_ham_low;
    assign dec_bus.word   = {hamming_word_high, hamming_word_mid, reg_wdata};
    assign dec_bus.mode   = decode_scheme_select;

    tthd_hamming u_hamming (
        .dec (dec_bus)
    );

    // flag set wins over software clear
    assign flag_clear = reg_wr && hit_ham_high && !reg_wdata[`TTHD_BIT_FLAG_HIGH];
    assign next_flag  = (decode_trigger && dec_bus.err) || (result_flag && !flag_clear);

    // data forced to zero under error
    assign next_data  = next_flag ? 18'h00000 :
                        (decode_trigger ? dec_bus.data : result_data);

    assign read_word = (result_mode == TTHD_MODE_2418) ?
                       {result_flag, result_data[17:11], 3'h0, result_data[10:6],
                        2'h0, result_data[5:0]} :
                       {19'h00000, result_flag, result_data[3:0]};

    assign ptr_load_ok  = !vbi_active;
    assign wr_ptr_high  = reg_wr && hit_ptr_high && ptr_load_ok;
    assign wr_ptr_low   = reg_wr && hit_ptr_low && ptr_load_ok;
    assign next_pointer = wr_ptr_high ? {reg_wdata[4:0], write_pointer[7:0]} :
                          wr_ptr_low ? {write_pointer[12:8], reg_wdata} :
                          store_strobe ? 13'(write_pointer + 13'h0001) :
                          write_pointer;

    // reserved bits read at reset values
    assign slicer_ctrl_read = {slicer_on_bit, extended_runin_search, gain_code,
                               1'b0, slicer_ctrl_reset[2:0]};
    assign dac_init_read    = {2'h0, dac_start_value};
    assign amplifier_bypass_sel_read  = {5'h00, bypass_bit, 1'b0, adc_sel_bit};

    // read mux; unmapped reads give zero
    always_comb begin
        next_rdata = 8'h00;
        if (hit_ptr_high) begin
            next_rdata = {3'h0, write_pointer[12:8]};
        end else if (hit_ptr_low) begin
            next_rdata = write_pointer[7:0];
        end else if (hit_scheme) begin
            next_rdata = {decode_scheme_select, 7'h00};
        end else if (hit_ham_high) begin
            next_rdata = read_word[23:16];
        end else if (hit_ham_mid) begin
            next_rdata = read_word[15:8];
        end else if (hit_ham_low) begin
            next_rdata = read_word[7:0];
        end else if (hit_slicer_ctrl) begin
            next_rdata = slicer_ctrl_read;
        end else if (hit_dac_init) begin
            next_rdata = dac_init_read;
        end else if (hit_amplifier_bypass_sel) begin
            next_rdata = amplifier_bypass_sel_read;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 8'h00;
        end else if (reg_rd) begin
            rdata <= next_rdata;
        end
    end

    // raw word bytes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hamming_word_high <= 8'h00;
            hamming_word_mid  <= 8'h00;
        end else if (reg_wr) begin
            if (hit_ham_high) begin
                hamming_word_high <= reg_wdata;
            end
            if (hit_ham_mid) begin
                hamming_word_mid <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            decode_scheme_select <= TTHD_MODE_84;
        end else if (reg_wr && hit_scheme) begin
            decode_scheme_select <= tthd_mode_e'(reg_wdata[`TTHD_BIT_SCHEME]);
        end
    end

    // result latched in the write cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            result_flag <= 1'b0;
            result_data <= 18'h00000;
            result_mode <= TTHD_MODE_84;
        end else begin
            result_flag <= next_flag;
            result_data <= next_data;
            if (decode_trigger) begin
                result_mode <= decode_scheme_select;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            write_pointer <= `TTHD_RST_PTR;
        end else begin
            write_pointer <= next_pointer;
        end
    end

    // slicer control fields
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            slicer_on_bit         <= slicer_ctrl_reset[`TTHD_BIT_SLICER_ON];
            extended_runin_search <= slicer_ctrl_reset[`TTHD_BIT_EXT_SEARCH];
            gain_code             <= slicer_ctrl_reset[`TTHD_BIT_GAIN_HI:`TTHD_BIT_GAIN_LO];
        end else if (reg_wr && hit_slicer_ctrl) begin
            slicer_on_bit         <= reg_wdata[`TTHD_BIT_SLICER_ON];
            extended_runin_search <= reg_wdata[`TTHD_BIT_EXT_SEARCH];
            gain_code             <= reg_wdata[`TTHD_BIT_GAIN_HI:`TTHD_BIT_GAIN_LO];
        end
    end

    // decoded slicer fields held in flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            runin_field1 <= `TTHD_LINE_F1_NORMAL;
            runin_field2 <= `TTHD_LINE_F2_NORMAL;
            gain_x10     <= `TTHD_GAIN_00;
        end else if (reg_wr && hit_slicer_ctrl) begin
            runin_field1 <= reg_wdata[`TTHD_BIT_EXT_SEARCH] ? `TTHD_LINE_F1_EXT :
                            `TTHD_LINE_F1_NORMAL;
            runin_field2 <= reg_wdata[`TTHD_BIT_EXT_SEARCH] ? `TTHD_LINE_F2_EXT :
                            `TTHD_LINE_F2_NORMAL;
            gain_x10     <= gain_lookup(reg_wdata[`TTHD_BIT_GAIN_HI:`TTHD_BIT_GAIN_LO]);
        end
    end

    // dac init field
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dac_start_value <= `TTHD_RST_DAC_INIT;
        end else if (reg_wr && hit_dac_init) begin
            dac_start_value <= reg_wdata[5:0];
        end
    end

    // pre-amplifier and converter select
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bypass_bit  <= amplifier_bypass_sel_reset[`TTHD_BIT_BYPASS];
            adc_sel_bit <= amplifier_bypass_sel_reset[`TTHD_BIT_ADC_SEL];
        end else if (reg_wr && hit_amplifier_bypass_sel) begin
            bypass_bit  <= reg_wdata[`TTHD_BIT_BYPASS];
            adc_sel_bit <= reg_wdata[`TTHD_BIT_ADC_SEL];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dac_value  <= `TTHD_RST_DAC_INIT;
            dac_reload <= 1'b0;
        end else begin
            dac_reload <= line_start;
            if (line_start) begin
                dac_value <= dac_start_value;
            end
        end
    end

    assign reg_rdata         = rdata;
    assign acq_write_address = write_pointer;

    assign slicer_on         = slicer_on_bit;
    assign slicer_power_down = !slicer_on_bit;

    assign runin_line_field1 = runin_field1;
    assign runin_line_field2 = runin_field2;
    assign amplifier_bypass_gain_field = gain_code;
    assign amplifier_bypass_gain_x10   = gain_x10;

    assign slicer_dac_value  = dac_value;
    assign slicer_dac_reload = dac_reload;

    assign amplifier_bypass      = bypass_bit;
    assign slicer_feed_amplified = !bypass_bit;

    assign converter_source_select       = adc_sel_bit;
    assign route_sync_amplitude_signal   = !adc_sel_bit;
    assign route_onchip_reference_signal = adc_sel_bit;

endmodule // tthd_regs

// >>> test/tthd_regs_props.sv
`timescale 1ns/10ps
module tthd_regs_props
    import tthd_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        store_strobe,
    input wire logic        line_start,
    input wire logic [12:0] acq_write_address,
    input wire logic        slicer_on,
    input wire logic        slicer_power_down,
    input wire logic [8:0]  runin_line_field1,
    input wire logic [8:0]  runin_line_field2,
    input wire logic [1:0]  amplifier_bypass_gain_field,
    input wire logic [5:0]  amplifier_bypass_gain_x10,
    input wire logic [5:0]  slicer_dac_value,
    input wire logic        slicer_dac_reload,
    input wire logic        amplifier_bypass,
    input wire logic        slicer_feed_amplified,
    input wire logic        converter_source_select,
    input wire logic        route_sync_amplitude_signal,
    input wire logic        route_onchip_reference_signal
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // expected gain in tenths per code
    wire [5:0] gain_exp = (amplifier_bypass_gain_field == 2'h0) ? 6'h0c :
                          (amplifier_bypass_gain_field == 2'h1) ? 6'h14 :
                          (amplifier_bypass_gain_field == 2'h2) ? 6'h1e : 6'h26;

    a_power_inverse: assert property (slicer_power_down != slicer_on)
        else $error("power down not inverse of slicer on");
    a_runin_pair: assert property ((runin_line_field1 == 9'h006 && runin_line_field2 == 9'h13e)
        || (runin_line_field1 == 9'h002 && runin_line_field2 == 9'h13b))
        else $error("run-in start lines not a legal pair");
    a_gain_map: assert property (amplifier_bypass_gain_x10 == gain_exp)
        else $error("gain value does not match gain code");
    a_dac_reload: assert property (line_start |=> slicer_dac_reload)
        else $error("no reload after line start");
    a_reload_quiet: assert property (!line_start |=> !slicer_dac_reload)
        else $error("reload without line start");
    a_dac_held: assert property (!line_start |=> $stable(slicer_dac_value))
        else $error("dac value changed without line start");
    a_feed_inverse: assert property (slicer_feed_amplified != amplifier_bypass)
        else $error("amplified feed not inverse of bypass");
    a_conv_route: assert property (route_onchip_reference_signal == converter_source_select
        && route_sync_amplitude_signal != converter_source_select)
        else $error("converter routing wrong");
    a_ptr_step: assert property (store_strobe && !reg_wr |=>
        acq_write_address == $past(acq_write_address) + 13'h0001)
        else $error("pointer did not step by one");
    a_ptr_hold: assert property (!store_strobe && !reg_wr |=> $stable(acq_write_address))
        else $error("pointer changed without store or write");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without read");

    c_line: cover property (line_start ##1 slicer_dac_reload);
    c_store: cover property (store_strobe && !reg_wr);
    c_bypass: cover property (slicer_on && amplifier_bypass);
endmodule // tthd_regs_props

// >>> test/tthd_regs_test.sv
`timescale 1ns/10ps
`include "tthd_params.svh"
module tthd_regs_test
    import tthd_pkg::*;
;
    typedef struct packed {
        logic       mode;
        tthd_word_t wr;
        tthd_word_t rd;
    } tthd_row_s;

    logic        clk, reset_n, reg_wr, reg_rd, store_strobe, vbi_active, line_start;
    logic [7:0]  reg_page, reg_addr, reg_wdata, reg_rdata;
    logic [12:0] acq_write_address;
    logic        slicer_on, slicer_power_down, slicer_dac_reload, amplifier_bypass;
    logic        slicer_feed_amplified, converter_source_select;
    logic        route_sync_amplitude_signal, route_onchip_reference_signal;
    logic [8:0]  runin_line_field1, runin_line_field2;
    logic [1:0]  amplifier_bypass_gain_field;
    logic [5:0]  amplifier_bypass_gain_x10, slicer_dac_value;
    logic [5:0]  gain_tab [4] = '{6'h0c, 6'h14, 6'h1e, 6'h26};
    int          error_cnt, check_count, cycles;
    tthd_byte_t  rb;
    tthd_word_t  got;
    tthd_row_s   rows [11] = '{
        '{1'b0, 24'h5ac315, 24'h000000},
        '{1'b0, 24'h5ac3ea, 24'h00000f},
        '{1'b0, 24'h5ac3aa, 24'h00000f},
        '{1'b0, 24'h5ac31f, 24'h000010},
        '{1'b0, 24'hffc3ea, 24'h000010},
        '{1'b1, 24'h00808b, 24'h000000},
        '{1'b1, 24'hff7f74, 24'h7f1f3f},
        '{1'b1, 24'hff7f70, 24'h7f1f3f},
        '{1'b1, 24'hff7f60, 24'h800000},
        '{1'b1, 24'hff7f74, 24'h800000},
        '{1'b1, 24'h00808b, 24'h000000}
    };

    tthd_regs dut (.*);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            close_out();
        end
    end

    task automatic close_out();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one register access, read data captured after its edge
    task automatic acc(input logic rd, input tthd_byte_t pg, ad, d);
        @(negedge clk);
        reg_page = pg;
        reg_addr = ad;
        reg_wdata = d;
        reg_rd = rd;
        reg_wr = !rd;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        rb = reg_rdata;
    endtask

    task automatic rchk(input string name, input tthd_byte_t pg, ad, exp);
        acc(1'b1, pg, ad, 8'h00);
        chk(name, exp, rb);
    endtask

    initial begin
        {reset_n, reg_wr, reg_rd, store_strobe, vbi_active, line_start} = 6'h00;
        {reg_page, reg_addr, reg_wdata} = 24'h000000;
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        for (int i = 0; i < 11; i++) begin
            acc(1'b0, `TTHD_PAGE_ACQ, `TTHD_OFS_SCHEME, {rows[i].mode, 7'h7f});
            rchk("scheme", `TTHD_PAGE_ACQ, `TTHD_OFS_SCHEME, {rows[i].mode, 7'h00});
            acc(1'b0, `TTHD_PAGE_ACQ, `TTHD_OFS_HAM_HIGH, rows[i].wr[23:16]);
            acc(1'b0, `TTHD_PAGE_ACQ, `TTHD_OFS_HAM_MID, rows[i].wr[15:8]);
            acc(1'b0, `TTHD_PAGE_ACQ, `TTHD_OFS_HAM_LOW, rows[i].wr[7:0]);
            acc(1'b1, `TTHD_PAGE_ACQ, `TTHD_OFS_HAM_HIGH, 8'h00);
            got[23:16] = rb;
            acc(1'b1, `TTHD_PAGE_ACQ, `TTHD_OFS_HAM_MID, 8'h00);
            got[15:8] = rb;
            acc(1'b1, `TTHD_PAGE_ACQ, `TTHD_OFS_HAM_LOW, 8'h00);
            got[7:0] = rb;
            chk("hamming word", rows[i].rd, got);
        end
        // slicer enable, search lines and gain codes
        for (int g = 0; g < 8; g++) begin
            acc(1'b0, `TTHD_PAGE_SLICER, `TTHD_OFS_SLICER_CTRL, {1'b1, g[2], g[1:0], 4'hf});
            rchk("slicer control", `TTHD_PAGE_SLICER, `TTHD_OFS_SLICER_CTRL,
                 {1'b1, g[2], g[1:0], 4'h6});
            chk("slicer on", 2'h2, {slicer_on, slicer_power_down});
            chk("runin", g[2] ? {9'h002, 9'h13b} : {9'h006, 9'h13e},
                {runin_line_field1, runin_line_field2});
            chk("gain", {g[1:0], gain_tab[g[1:0]]},
                {amplifier_bypass_gain_field, amplifier_bypass_gain_x10});
        end
        // dac init only reaches the dac at line start
        acc(1'b0, `TTHD_PAGE_SLICER, `TTHD_OFS_DAC_INIT, 8'hf5);
        rchk("dac init", `TTHD_PAGE_SLICER, `TTHD_OFS_DAC_INIT, 8'h35);
        chk("dac value", 6'h0b, slicer_dac_value);
        @(negedge clk);
        line_start = 1'b1;
        @(negedge clk);
        line_start = 1'b0;
        chk("dac reload", {1'b1, 6'h35}, {slicer_dac_reload, slicer_dac_value});
        @(negedge clk);
        chk("dac reload end", 1'b0, slicer_dac_reload);
        for (int s = 1; s >= 0; s--) begin
            acc(1'b0, `TTHD_PAGE_SLICER, `TTHD_OFS_AMPLIFIER_BYPASS_SEL, s ? 8'hff : 8'h00);
            rchk("select", `TTHD_PAGE_SLICER, `TTHD_OFS_AMPLIFIER_BYPASS_SEL, s ? 8'h05 : 8'h00);
            chk("select outputs", s ? 5'h15 : 5'h0a,
                {amplifier_bypass, slicer_feed_amplified, converter_source_select,
                 route_sync_amplitude_signal, route_onchip_reference_signal});
        end
        // pointer load, wrap on store, lock during blanking
        acc(1'b0, `TTHD_PAGE_ACQ, `TTHD_OFS_PTR_LOW, 8'hfe);
        acc(1'b0, `TTHD_PAGE_ACQ, `TTHD_OFS_PTR_HIGH, 8'hff);
        rchk("pointer high", `TTHD_PAGE_ACQ, `TTHD_OFS_PTR_HIGH, 8'h1f);
        rchk("pointer low", `TTHD_PAGE_ACQ, `TTHD_OFS_PTR_LOW, 8'hfe);
        @(negedge clk);
        store_strobe = 1'b1;
        @(negedge clk);
        @(negedge clk);
        store_strobe = 1'b0;
        chk("pointer wrap", 13'h0000, acq_write_address);
        vbi_active = 1'b1;
        acc(1'b0, `TTHD_PAGE_ACQ, `TTHD_OFS_PTR_LOW, 8'h55);
        chk("pointer locked", 13'h0000, acq_write_address);
        vbi_active = 1'b0;
        acc(1'b0, `TTHD_PAGE_ACQ, `TTHD_OFS_PTR_LOW, 8'h55);
        chk("pointer load", 13'h0055, acq_write_address);
        acc(1'b0, `TTHD_PAGE_ACQ, 8'h10, 8'hff);
        rchk("unmapped", `TTHD_PAGE_ACQ, 8'h10, 8'h00);
        // reset in mid-run restores documented values
        @(negedge clk);
        reset_n = 1'b0;
        @(negedge clk);
        reset_n = 1'b1;
        rchk("slicer control", `TTHD_PAGE_SLICER, `TTHD_OFS_SLICER_CTRL, 8'h06);
        rchk("dac init", `TTHD_PAGE_SLICER, `TTHD_OFS_DAC_INIT, 8'h0b);
        rchk("select", `TTHD_PAGE_SLICER, `TTHD_OFS_AMPLIFIER_BYPASS_SEL, 8'h00);
        chk("reset outputs", {1'b0, 9'h006, 6'h0b, 13'h0000},
            {slicer_on, runin_line_field1, slicer_dac_value, acq_write_address});
        close_out();
    end
endmodule // tthd_regs_test

bind tthd_regs tthd_regs_props u_props (.*);
